/* File: hdl/brc_pkg.sv */
package brc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] BRC_OFF_CTRL = 12'h000;
	localparam logic [11:0] BRC_OFF_CDB = 12'h004;
	localparam logic [11:0] BRC_OFF_ADDR = 12'h008;
	localparam logic [11:0] BRC_OFF_LEN = 12'h00C;
	localparam logic [11:0] BRC_OFF_STAT = 12'h010;
	localparam logic [11:0] BRC_OFF_SENT = 12'h014;
	localparam logic [11:0] BRC_OFF_BPTR = 12'h018;
	localparam logic [11:0] BRC_OFF_BDATA = 12'h01C;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned BRC_CTRL_START_BIT = 0;
	localparam int unsigned BRC_STAT_BUSY_BIT = 0;
	localparam int unsigned BRC_STAT_DONE_BIT = 1;
	localparam int unsigned BRC_STAT_CHECK_BIT = 2;
	localparam int unsigned BRC_CDB_MODE_LSB = 0;
	localparam int unsigned BRC_CDB_ID_LSB = 8;
	localparam logic [23:0] BRC_RST_ADDR = 24'h000000;
	localparam logic [23:0] BRC_RST_LEN = 24'h000000;
	localparam logic [7:0] BRC_RST_ID = 8'h00;

	// ----------------------------------------------------------------
	// buffer geometry and fixed reply bytes
	// ----------------------------------------------------------------
	localparam logic [23:0] BRC_BUF_BYTES = 24'h006000;
	localparam logic [23:0] BRC_HDR_BYTES = 24'h000004;
	localparam logic [7:0] BRC_ADDR_EXP = 8'h00;
	localparam logic [7:0] BRC_HDR_ZERO = 8'h00;
	localparam int unsigned BRC_PTR_W = 15;
	localparam int unsigned BRC_FIFO_DEPTH = 32;

	typedef enum logic [2:0] {
		BRC_MODE_HDR = 3'h0,
		BRC_MODE_HDR_ADDR = 3'h1,
		BRC_MODE_DATA = 3'h2,
		BRC_MODE_DESC = 3'h3
	} brc_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} brc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} brc_apb_rsp_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} brc_strm_t;

endpackage

/* File: hdl/brc_readback.sv */
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - header modes send a 4-byte header: a zero byte, then the usable length MSB first.
// - the reported usable length depends on buffer capacity and, in header mode with address, on the address; never on the length.
// - header mode without address sends min(length - 4, usable length) buffer bytes.
// - header mode with address reports the span from the address to the last byte.
// - header mode with address sends header then min(length - 4, span) bytes from the address.
// - addressed modes stop at the requested count or the last byte, with good completion.
// - a zero transfer length moves no data and completes normally in every mode.
// - data-only mode sends no header and starts at the given buffer address.
// - data-only mode sends min(length, bytes remaining to the last location).
// - descriptor mode sends only min(length, 4) descriptor bytes; initiator zeroes id and address.
// - descriptor byte 0 is the addressing exponent, reported as zero (byte granular).
// - descriptor bytes 1 to 3 hold the usable size, 24 KB, MSB first.
// - header mode without address reads the buffer from location zero.
// - one 24576-byte buffer, byte addressed from zero to hex 5FFF.

// ------------------------------------------------------------------
// byte fifo with registered output stage
// ------------------------------------------------------------------
module brc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input wire logic clk, // clock
	input wire logic rstSyncB, // synchronised reset, low active
	input wire logic ce, // clock enable
	input wire logic inValid, // write request
	input wire logic [WIDTH-1:0] inData, // write data
	output logic inReady, // room for a word
	output logic outValid, // output word present
	output logic [WIDTH-1:0] outData, // output word
	input wire logic outReady, // consumer takes word
	output logic idle // nothing stored at all
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
		logic outValid;
		logic [WIDTH-1:0] outData;
	} brc_fifo_st_t;

	brc_fifo_st_t fifo_q, fifo_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	always_comb begin
		push = inValid && inReady;
		pop = (fifo_q.count != '0) && (!fifo_q.outValid || outReady);
		fifo_d = fifo_q;
		if (push) begin
			fifo_d.wrPtr = (fifo_q.wrPtr == AW'(DEPTH - 1)) ? '0 : fifo_q.wrPtr + 1'b1;
		end
		if (pop) begin
			fifo_d.rdPtr = (fifo_q.rdPtr == AW'(DEPTH - 1)) ? '0 : fifo_q.rdPtr + 1'b1;
			fifo_d.outData = mem[fifo_q.rdPtr];
			fifo_d.outValid = 1'b1;
		end else if (outReady) begin
			fifo_d.outValid = 1'b0;
		end
		if (push && !pop) begin
			fifo_d.count = fifo_q.count + 1'b1;
		end else if (pop && !push) begin
			fifo_d.count = fifo_q.count - 1'b1;
		end
	end

	// the full flag stalls the sequencer, so bytes are never dropped
	assign inReady = fifo_q.count != (AW + 1)'(DEPTH);
	assign outValid = fifo_q.outValid;
	assign outData = fifo_q.outData;
	assign idle = (fifo_q.count == '0) && !fifo_q.outValid;

	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[fifo_q.wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rstSyncB) begin
		if (!rstSyncB) begin
			fifo_q <= '0;
		end else if (ce) begin
			fifo_q <= fifo_d;
		end
	end
endmodule

// ------------------------------------------------------------------
// buffer readback command engine
// ------------------------------------------------------------------
module brc_readback
	import brc_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = BRC_FIFO_DEPTH
) (
	input wire logic clk, // 100 MHz clock
	input wire logic rst_b, // async reset, low active
	input wire logic ce, // clock enable, freezes all state but the reset synchroniser
	input wire brc_pkg::brc_apb_req_t apbReq, // apb request from master
	output brc_pkg::brc_apb_rsp_t apbRsp, // apb answer
	output brc_pkg::brc_strm_t strm, // bytes toward the initiator
	input wire logic strmReady // initiator side accepts byte
);
	import brc_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_EVAL, ST_HDR, ST_DATA, ST_DRAIN} brc_state_t;

	typedef struct packed {
		brc_state_t st;
		logic [2:0] mode;
		logic [7:0] bufId;
		logic [23:0] addr;
		logic [23:0] len;
		logic busy;
		logic done;
		logic check;
		logic [23:0] sent;
		logic [BRC_PTR_W-1:0] wrPtr;
		logic [2:0] hdrLeft;
		logic [1:0] hdrIdx;
		logic [23:0] dataLeft;
		logic [BRC_PTR_W-1:0] rdPtr;
		logic [23:0] span;
		brc_apb_rsp_t rsp;
	} brc_regs_t;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rstSync_q;
	logic rstSyncB;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync_q <= 2'b00;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstSyncB = rstSync_q[1];

	function automatic logic [23:0] brcMin(input logic [23:0] a, input logic [23:0] b);
		brcMin = (a < b) ? a : b;
	endfunction

	// ----------------------------------------------------------------
	// state and buffer storage
	// ----------------------------------------------------------------
	brc_regs_t s_q, s_d;
	logic [7:0] bufMem [int'(BRC_BUF_BYTES)];
	logic bufWe;
	logic fifoInReady, fifoIdle, push, badCmd, apbAcc, apbWr;
	logic [7:0] pushData;
	logic [23:0] hdrVal, dataAvail;
	logic [11:0] off;

	always_comb begin
		off = apbReq.paddr;
		apbAcc = apbReq.psel && apbReq.penable;
		apbWr = apbAcc && apbReq.pwrite && s_q.rsp.pready;
		// identifier and mode are checked before any byte moves
		badCmd = (s_q.bufId != BRC_RST_ID) || (s_q.mode > 3'(BRC_MODE_DESC));
		push = ((s_q.st == ST_HDR) || (s_q.st == ST_DATA)) && fifoInReady;
		// descriptor reports full capacity, header modes report the span
		hdrVal = (s_q.mode == 3'(BRC_MODE_DESC)) ? BRC_BUF_BYTES : s_q.span;
		unique case (s_q.hdrIdx)
			2'd0: pushData = (s_q.mode == 3'(BRC_MODE_DESC)) ? BRC_ADDR_EXP : BRC_HDR_ZERO;
			2'd1: pushData = hdrVal[23:16];
			2'd2: pushData = hdrVal[15:8];
			default: pushData = hdrVal[7:0];
		endcase
		if (s_q.st == ST_DATA) begin
			pushData = bufMem[s_q.rdPtr];
		end
		dataAvail = (s_q.len > BRC_HDR_BYTES) ? s_q.len - BRC_HDR_BYTES : 24'h000000;
		bufWe = ce && apbWr && (off == BRC_OFF_BDATA) && !s_q.busy;

		s_d = s_q;
		// ------------------------------------------------------------
		// apb slave: one wait state, effects at the ready edge
		// ------------------------------------------------------------
		s_d.rsp.pready = apbAcc && !s_q.rsp.pready;
		s_d.rsp.pslverr = 1'b0;
		s_d.rsp.prdata = 32'h00000000;
		if (apbAcc && !s_q.rsp.pready) begin
			case (off)
				BRC_OFF_CTRL: s_d.rsp.prdata = 32'h00000000;
				BRC_OFF_CDB: s_d.rsp.prdata = {16'h0000, s_q.bufId, 5'h00, s_q.mode};
				BRC_OFF_ADDR: s_d.rsp.prdata = {8'h00, s_q.addr};
				BRC_OFF_LEN: s_d.rsp.prdata = {8'h00, s_q.len};
				BRC_OFF_STAT: s_d.rsp.prdata = {29'h00000000, s_q.check, s_q.done, s_q.busy};
				BRC_OFF_SENT: s_d.rsp.prdata = {8'h00, s_q.sent};
				BRC_OFF_BPTR: s_d.rsp.prdata = {17'h00000, s_q.wrPtr};
				BRC_OFF_BDATA: s_d.rsp.prdata = 32'h00000000;
				default: s_d.rsp.pslverr = 1'b1;
			endcase
		end
		// command fields are frozen while a command runs
		if (apbWr && !s_q.busy) begin
			case (off)
				BRC_OFF_CDB: begin
					s_d.mode = apbReq.pwdata[BRC_CDB_MODE_LSB +: 3];
					s_d.bufId = apbReq.pwdata[BRC_CDB_ID_LSB +: 8];
				end
				BRC_OFF_ADDR: s_d.addr = apbReq.pwdata[23:0];
				BRC_OFF_LEN: s_d.len = apbReq.pwdata[23:0];
				BRC_OFF_BPTR: s_d.wrPtr = apbReq.pwdata[BRC_PTR_W-1:0];
				BRC_OFF_BDATA: begin
					s_d.wrPtr = (s_q.wrPtr == BRC_PTR_W'(BRC_BUF_BYTES - 24'h1)) ? '0 :
						s_q.wrPtr + 1'b1;
				end
				BRC_OFF_CTRL: begin
					if (apbReq.pwdata[BRC_CTRL_START_BIT]) begin
						s_d.busy = 1'b1;
						s_d.done = 1'b0;
						s_d.check = 1'b0;
						s_d.sent = 24'h000000;
						s_d.st = ST_EVAL;
					end
				end
				default: s_d.busy = s_q.busy;
			endcase
		end

		// ------------------------------------------------------------
		// command sequencer
		// ------------------------------------------------------------
		case (s_q.st)
			ST_IDLE: s_d.hdrIdx = 2'd0;
			ST_EVAL: begin
				s_d.hdrIdx = 2'd0;
				s_d.hdrLeft = 3'd0;
				s_d.dataLeft = 24'h000000;
				if (badCmd || (((s_q.mode == 3'(BRC_MODE_HDR_ADDR)) || (s_q.mode == 3'(BRC_MODE_DATA)))
					&& (s_q.addr >= BRC_BUF_BYTES) && (s_q.len != 24'h000000))) begin
					s_d.check = 1'b1;
					s_d.done = 1'b1;
					s_d.busy = 1'b0;
					s_d.st = ST_IDLE;
				end else begin
					// capacity, less the address in the addressed modes; never the requested length
					s_d.span = (s_q.mode == 3'(BRC_MODE_HDR) || s_q.mode == 3'(BRC_MODE_DESC)) ?
						BRC_BUF_BYTES : BRC_BUF_BYTES - s_q.addr;
					s_d.rdPtr = (s_q.mode == 3'(BRC_MODE_HDR)) ? '0 :
						s_q.addr[BRC_PTR_W-1:0];
					case (s_q.mode)
						3'(BRC_MODE_HDR), 3'(BRC_MODE_HDR_ADDR): begin
							s_d.hdrLeft = 3'(brcMin(s_q.len, BRC_HDR_BYTES));
							s_d.dataLeft = brcMin(dataAvail, s_d.span);
						end
						3'(BRC_MODE_DATA): s_d.dataLeft = brcMin(s_q.len, s_d.span);
						default: s_d.hdrLeft = 3'(brcMin(s_q.len, BRC_HDR_BYTES));
					endcase
					// a zero length falls straight through to completion
					if (s_d.hdrLeft != 3'd0) begin
						s_d.st = ST_HDR;
					end else if (s_d.dataLeft != 24'h000000) begin
						s_d.st = ST_DATA;
					end else begin
						s_d.st = ST_DRAIN;
					end
				end
			end
			ST_HDR: begin
				if (push) begin
					s_d.hdrIdx = s_q.hdrIdx + 2'd1;
					s_d.hdrLeft = s_q.hdrLeft - 3'd1;
					s_d.sent = s_q.sent + 24'h1;
					if (s_q.hdrLeft == 3'd1) begin
						s_d.st = (s_q.dataLeft != 24'h000000) ? ST_DATA : ST_DRAIN;
					end
				end
			end
			ST_DATA: begin
				if (push) begin
					s_d.rdPtr = s_q.rdPtr + 1'b1;
					s_d.dataLeft = s_q.dataLeft - 24'h1;
					s_d.sent = s_q.sent + 24'h1;
					// count met or last location sent: good end either way
					if (s_q.dataLeft == 24'h1) begin
						s_d.st = ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				// status waits until the initiator has every byte
				if (fifoIdle) begin
					s_d.done = 1'b1;
					s_d.busy = 1'b0;
					s_d.st = ST_IDLE;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (bufWe) begin
			bufMem[s_q.wrPtr] <= apbReq.pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rstSyncB) begin
		if (!rstSyncB) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.addr <= BRC_RST_ADDR;
			s_q.len <= BRC_RST_LEN;
			s_q.bufId <= BRC_RST_ID;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign apbRsp = s_q.rsp;

	// ----------------------------------------------------------------
	// outgoing byte fifo
	// ----------------------------------------------------------------
	brc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rstSyncB(rstSyncB),
		.ce(ce),
		.inValid((s_q.st == ST_HDR) || (s_q.st == ST_DATA)),
		.inData(pushData),
		.inReady(fifoInReady),
		.outValid(strm.valid),
		.outData(strm.data),
		.outReady(strmReady),
		.idle(fifoIdle)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSyncB);

	property p_hdr_zero;
		(ce && push && s_q.st == ST_HDR && s_q.hdrIdx == 2'd0) |-> pushData == 8'h00;
	endproperty
	a_hdr_zero: assert property (p_hdr_zero) else $error("first header byte not zero");

	property p_span_full;
		(s_q.st == ST_HDR && s_q.mode == 3'(BRC_MODE_HDR)) |-> s_q.span == BRC_BUF_BYTES;
	endproperty
	a_span_full: assert property (p_span_full) else $error("length not capacity");

	property p_span_addr;
		(s_q.st == ST_HDR && s_q.mode == 3'(BRC_MODE_HDR_ADDR)) |->
			s_q.span == BRC_BUF_BYTES - s_q.addr;
	endproperty
	a_span_addr: assert property (p_span_addr) else $error("span wrong");

	property p_clip;
		(ce && s_q.st == ST_EVAL && !badCmd && s_q.mode != 3'(BRC_MODE_DATA)) |=>
			s_q.dataLeft <= dataAvail && s_q.dataLeft <= s_q.span;
	endproperty
	a_clip: assert property (p_clip) else $error("data count not clipped");

	property p_last;
		(ce && push && s_q.st == ST_DATA && s_q.dataLeft == 24'h1) |=>
			s_q.st == ST_DRAIN && !s_q.check;
	endproperty
	a_last: assert property (p_last) else $error("transfer not stopped");

	property p_zero_len;
		(ce && s_q.st == ST_EVAL && !badCmd && s_q.len == 24'h0) |=>
			s_q.st == ST_DRAIN ##1 (s_q.done && !s_q.check);
	endproperty
	a_zero_len: assert property (p_zero_len) else $error("zero length moved data");

	property p_data_only;
		(ce && s_q.st == ST_EVAL && !badCmd && s_q.mode == 3'(BRC_MODE_DATA) &&
			s_q.addr < BRC_BUF_BYTES) |=>
			s_q.hdrLeft == 3'd0 && s_q.rdPtr == $past(s_q.addr[BRC_PTR_W-1:0]);
	endproperty
	a_data_only: assert property (p_data_only) else $error("data-only start wrong");

	property p_desc;
		(ce && s_q.st == ST_EVAL && !badCmd && s_q.mode == 3'(BRC_MODE_DESC)) |=>
			s_q.dataLeft == 24'h0 && s_q.hdrLeft <= 3'd4 && s_q.hdrLeft <= $past(s_q.len);
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor length wrong");

	property p_bad;
		(ce && s_q.st == ST_EVAL && badCmd) |=> s_q.check && s_q.st == ST_IDLE && s_q.sent == 24'h0;
	endproperty
	a_bad: assert property (p_bad) else $error("bad command not refused");

	property p_from_zero;
		(ce && s_q.st == ST_EVAL && !badCmd && s_q.mode == 3'(BRC_MODE_HDR)) |=> s_q.rdPtr == '0;
	endproperty
	a_from_zero: assert property (p_from_zero) else $error("read not from zero");
endmodule

/* File: sim/brc_init_sink.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// initiator side: takes bytes, may stall or accept every other cycle
// ------------------------------------------------------------------
module brc_init_sink
	import brc_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst_b, // reset, low active
	input wire brc_pkg::brc_strm_t strm, // bytes from the device
	input wire logic stall, // hold off every byte
	input wire logic slow, // accept on alternate cycles only
	output logic strmReady // byte accepted at this edge
);
	logic [7:0] got[$];

	// ready is registered so the device never sees it move mid-cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strmReady <= 1'b0;
		end else begin
			if (strm.valid === 1'b1 && strmReady) begin
				got.push_back(strm.data);
			end
			strmReady <= !stall && (!slow || !strmReady);
		end
	end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import brc_pkg::*;
	logic clk;
	logic rst_b;
	logic stall;
	logic slow;
	logic strmReady;
	brc_apb_req_t apbReq;
	brc_apb_rsp_t apbRsp;
	brc_strm_t strm;
	logic [31:0] rdData;
	logic rdErr;
	logic [7:0] mem [0:24575];
	logic [7:0] expQ[$];
	int failCount;
	int totalChecks;

	brc_readback #(.FIFO_DEPTH(32)) dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
		.apbReq(apbReq), .apbRsp(apbRsp), .strm(strm), .strmReady(strmReady));
	brc_init_sink sink (.clk(clk), .rst_b(rst_b), .strm(strm), .stall(stall),
		.slow(slow), .strmReady(strmReady));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task complete_run;
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// waits for the slave however long it takes; only the watchdog ends a hang
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		apbReq.psel <= 1'b1;
		apbReq.penable <= 1'b0;
		apbReq.pwrite <= wr;
		apbReq.paddr <= a;
		apbReq.pwdata <= wd;
		@(posedge clk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (apbRsp.pready !== 1'b1);
		rdData = apbRsp.prdata;
		rdErr = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask

	task load(input int a, input int n);
		int k;
		apb(1'b1, BRC_OFF_BPTR, a);
		for (k = 0; k < n; k++) begin
			mem[(a + k) % 24576] = 8'((a + k) * 7 + 8'h5A);
			apb(1'b1, BRC_OFF_BDATA, {24'h0, mem[(a + k) % 24576]});
		end
		apb(1'b0, BRC_OFF_BPTR, 32'h0);
		chk("bptr", (a + n) % 24576, rdData);
	endtask

	// expected stream is built from the mode rules, never from the design
	task run_cmd(input logic [2:0] mode, input logic [7:0] id, input int addr, input int len,
		input logic expChk, input logic stallFirst);
		int span;
		int n;
		int k;
		expQ.delete();
		sink.got.delete();
		span = (mode == 3'h0 || mode == 3'h3) ? 24576 : 24576 - addr;
		if (!expChk) begin
			if (mode != 3'h2) begin
				for (k = 0; k < 4 && k < len; k++) begin
					expQ.push_back(k == 0 ? 8'h00 : 8'(span >> (8 * (3 - k))));
				end
			end
			if (mode < 3'h3) begin
				n = (mode == 3'h2) ? len : len - 4;
				if (n > span) n = span;
				for (k = 0; k < n; k++) begin
					expQ.push_back(mem[(mode == 3'h0) ? k : addr + k]);
				end
			end
		end
		stall <= stallFirst;
		apb(1'b1, BRC_OFF_CDB, {16'h0, id, 5'h0, mode});
		apb(1'b1, BRC_OFF_ADDR, addr);
		apb(1'b1, BRC_OFF_LEN, len);
		apb(1'b1, BRC_OFF_CTRL, 32'h1);
		if (stallFirst) begin
			repeat (100) @(posedge clk);
			apb(1'b0, BRC_OFF_STAT, 32'h0);
			chk("stat stalled", 32'h1, rdData);
			stall <= 1'b0;
		end
		n = 0;
		do begin
			apb(1'b0, BRC_OFF_STAT, 32'h0);
			n++;
		end while (rdData[BRC_STAT_DONE_BIT] !== 1'b1 && n < 300);
		chk("stat", expChk ? 32'h6 : 32'h2, rdData);
		chk("count", expQ.size(), sink.got.size());
		for (k = 0; k < expQ.size(); k++) begin
			chk("byte", {24'h0, expQ[k]}, {24'h0, sink.got[k]});
		end
		apb(1'b0, BRC_OFF_SENT, 32'h0);
		chk("sent", expQ.size(), rdData);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task t_regs;
		apb(1'b0, BRC_OFF_STAT, 32'h0);
		chk("stat reset", 32'h0, rdData);
		apb(1'b0, BRC_OFF_CDB, 32'h0);
		chk("cdb reset", 32'h0, rdData);
		apb(1'b0, BRC_OFF_ADDR, 32'h0);
		chk("addr reset", {8'h0, BRC_RST_ADDR}, rdData);
		apb(1'b0, BRC_OFF_LEN, 32'h0);
		chk("len reset", {8'h0, BRC_RST_LEN}, rdData);
		apb(1'b0, BRC_OFF_CTRL, 32'h0);
		chk("ctrl read", 32'h0, rdData);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rdErr});
		chk("unmapped data", 32'h0, rdData);
	endtask

	task t_desc;
		run_cmd(3'h3, 8'h00, 0, 4, 1'b0, 1'b0);
		run_cmd(3'h3, 8'h00, 0, 2, 1'b0, 1'b0);
		run_cmd(3'h3, 8'h00, 0, 9, 1'b0, 1'b0);
	endtask

	task t_hdr;
		load(0, 64);
		run_cmd(3'h0, 8'h00, 0, 7, 1'b0, 1'b0);
		run_cmd(3'h0, 8'h00, 0, 2, 1'b0, 1'b0);
		// fills the fifo while stalled, then drains it
		run_cmd(3'h0, 8'h00, 0, 68, 1'b0, 1'b1);
	endtask

	task t_addr;
		load(24574, 2);
		run_cmd(3'h1, 8'h00, 24574, 10, 1'b0, 1'b0);
		run_cmd(3'h1, 8'h00, 3, 9, 1'b0, 1'b0);
	endtask

	task t_data;
		slow <= 1'b1;
		run_cmd(3'h2, 8'h00, 24574, 100, 1'b0, 1'b0);
		run_cmd(3'h2, 8'h00, 1, 5, 1'b0, 1'b0);
		slow <= 1'b0;
	endtask

	task t_zero;
		int m;
		for (m = 0; m < 4; m++) begin
			run_cmd(3'(m), 8'h00, (m == 0 || m == 3) ? 0 : 2, 0, 1'b0, 1'b0);
		end
		// zero length ends well even where the address lies past the buffer
		run_cmd(3'h2, 8'h00, 24576, 0, 1'b0, 1'b0);
	endtask

	task t_bad;
		int m;
		for (m = 4; m < 8; m++) begin
			run_cmd(3'(m), 8'h00, 0, 8, 1'b1, 1'b0);
		end
		run_cmd(3'h0, 8'h01, 0, 8, 1'b1, 1'b0);
		run_cmd(3'h1, 8'h00, 24576, 8, 1'b1, 1'b0);
		run_cmd(3'h2, 8'h00, 24576, 4, 1'b1, 1'b0);
	endtask

	// ------------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst_b = 1'b0;
		stall = 1'b0;
		slow = 1'b0;
		apbReq = '0;
		failCount = 0;
		totalChecks = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_desc();
		t_hdr();
		t_addr();
		t_data();
		t_zero();
		t_bad();
		complete_run();
	end

	// the scenarios need well under 2,000 cycles; 20,000 leaves a wide margin
	initial begin
		#200us;
		failCount++;
		complete_run();
	end
endmodule
